// [fsc_map.svh]
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// Frequencies are carried in units of 0.01 Hz.
`define FSC_FREQ_W        16
// Analog, pulse and multi-segment inputs are in units of 0.1 percent.
`define FSC_PM_W          11
`define FSC_PM_FULL       34'h00000003e8
// Percent full scale for the auxiliary range setting.
`define FSC_PCT_FULL      34'h0000000064
// Divisor that removes both scalings at once.
`define FSC_SCALE_DIV     34'h00000186a0

// Decimal digit positions inside the packed selector codes.
`define FSC_DIGIT_BASE    10'h00a

// Reset defaults of the selection settings.
`define FSC_RST_MOTOR     1'b0
`define FSC_RST_MAIN_CH   4'h0
`define FSC_RST_AUX_CH    4'h0
`define FSC_RST_RANGE_REF 1'b0
`define FSC_RST_RANGE_PCT 8'h00
`define FSC_RST_COMB      6'h00
`define FSC_RST_OFFSET    16'h0000
`define FSC_RST_BIND      10'h000
`define FSC_RST_MAX_FREQ  16'h1388

`endif

// [fsc_pkg.sv]
package fsc_pkg;

  // Frequency channel codes, shared by main, auxiliary and binding selectors.
  typedef enum logic [3:0] {
    FSC_CH_NONE  = 4'h0,
    FSC_CH_DIG   = 4'h1,
    FSC_CH_AI1   = 4'h2,
    FSC_CH_AI2   = 4'h3,
    FSC_CH_AI3   = 4'h4,
    FSC_CH_PULSE = 4'h5,
    FSC_CH_MSEG  = 4'h6,
    FSC_CH_PLC   = 4'h7,
    FSC_CH_PID   = 4'h8,
    FSC_CH_COMM  = 4'h9
  } fsc_chan_e;

  // Active run-command channel.
  typedef enum logic [1:0] {
    FSC_CMD_PANEL = 2'h0,
    FSC_CMD_TERM  = 2'h1,
    FSC_CMD_COMM  = 2'h2
  } fsc_cmd_e;

  // Units digit of the combination select.
  typedef enum logic [3:0] {
    FSC_MODE_MAIN    = 4'h0,
    FSC_MODE_COMB    = 4'h1,
    FSC_MODE_SW_XY   = 4'h2,
    FSC_MODE_SW_XC   = 4'h3,
    FSC_MODE_SW_YC   = 4'h4
  } fsc_mode_e;

  // Tens digit of the combination select.
  typedef enum logic [3:0] {
    FSC_OP_SUM  = 4'h0,
    FSC_OP_DIFF = 4'h1,
    FSC_OP_MIN  = 4'h2,
    FSC_OP_MAX  = 4'h3
  } fsc_op_e;

  // Selection settings written by panel or serial link.
  typedef struct packed {
    logic        motor_set_select;
    logic [3:0]  main_source_channel;
    logic [3:0]  aux_source_channel;
    logic        aux_range_reference_select;
    logic [7:0]  aux_range_percent;
    logic [5:0]  source_combination_select;
    logic [15:0] combined_offset_frequency;
    logic [9:0]  command_channel_binding;
    logic [15:0] max_output_frequency;
  } fsc_cfg_s;

  // Live values of every frequency channel.
  typedef struct packed {
    logic [15:0] digital_freq;
    logic [15:0] updown_adjust;
    logic [10:0] analog_input_one;
    logic [10:0] analog_input_two;
    logic [10:0] analog_input_three;
    logic [10:0] pulse_frequency_input;
    logic [10:0] multi_segment;
    logic [15:0] plc_freq;
    logic [15:0] pid_freq;
    logic [15:0] comm_freq;
  } fsc_src_s;

endpackage : fsc_pkg

// [fsc_combiner.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"

module fsc_combiner
  import fsc_pkg::*;
(
  // Clock and reset.
  input  wire logic     clock,
  input  wire logic     sys_rst,
  // Settings load port.
  input  wire logic     cfg_we,
  input  wire fsc_cfg_s cfg_in,
  output fsc_cfg_s      cfg_out,
  // Channel values.
  input  wire fsc_src_s src,
  // Digital input terminals, asynchronous pins.
  input  wire logic     motor_term_pin,
  input  wire logic     motor_term_assigned,
  input  wire logic     switch_term_pin,
  input  wire logic     switch_term_assigned,
  // Active run-command channel.
  input  wire fsc_cmd_e cmd_source,
  // Results.
  output logic [15:0]   target_freq,
  output logic          active_motor,
  output logic          bound_in_use
);

  // Scales a 0.1 percent reading by a reference and a percent setting.
  function automatic logic [16:0] scale_pm(input logic [10:0] pm,
                                           input logic [16:0] ref_f,
                                           input logic [7:0]  pct);
    logic [33:0] prod;
    prod = {17'h00000, ref_f} * {23'h000000, pm} * {26'h0000000, pct};
    return 17'((prod / `FSC_SCALE_DIV));
  endfunction : scale_pm

  // Picks the raw reading of an analog-style channel.
  function automatic logic [10:0] chan_pm(input logic [3:0] code,
                                          input fsc_src_s   s);
    case (code)
      FSC_CH_AI1:   return s.analog_input_one;
      FSC_CH_AI2:   return s.analog_input_two;
      FSC_CH_AI3:   return s.analog_input_three;
      FSC_CH_PULSE: return s.pulse_frequency_input;
      default:      return s.multi_segment;
    endcase
  endfunction : chan_pm

  // True for channels whose value is a fraction of full scale.
  function automatic logic is_scaled(input logic [3:0] code);
    return (code >= FSC_CH_AI1) && (code <= FSC_CH_MSEG);
  endfunction : is_scaled

  // Decodes a channel code into a frequency; shared by main, aux and binding.
  function automatic logic [16:0] chan_value(input logic [3:0]  code,
                                             input fsc_src_s    s,
                                             input logic [15:0] maxf);
    if (is_scaled(code))
      return scale_pm(chan_pm(code, s), {1'b0, maxf}, 8'h64);
    case (code)
      FSC_CH_PLC:  return {1'b0, s.plc_freq};
      FSC_CH_PID:  return {1'b0, s.pid_freq};
      FSC_CH_COMM: return {1'b0, s.comm_freq};
      default:     return {1'b0, s.digital_freq};
    endcase
  endfunction : chan_value

  // Limits a result to the range zero to maximum frequency.
  function automatic logic [15:0] clamp_f(input logic [17:0] v,
                                          input logic [15:0] maxf);
    return (v > {2'b00, maxf}) ? maxf : v[15:0];
  endfunction : clamp_f

  // Extracts one decimal digit of a selector value.
  function automatic logic [3:0] digit(input logic [9:0] v,
                                       input logic [1:0] pos);
    logic [9:0] t;
    t = v;
    for (int i = 0; i < 2; i++) begin
      if (i < int'(pos))
        t = t / `FSC_DIGIT_BASE;
    end
    return 4'(t % `FSC_DIGIT_BASE);
  endfunction : digit

  // Settings and terminal synchronisers.
  fsc_cfg_s    cfg_r;
  logic [1:0]  motor_sync_r;
  logic [1:0]  switch_sync_r;
  logic [15:0] target_r;
  logic [15:0] target_nxt;
  logic        motor_r;
  logic        motor_nxt;
  logic        bound_r;

  // Settings hold their defaults after reset until software loads new ones.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_r.motor_set_select           <= `FSC_RST_MOTOR;
      cfg_r.main_source_channel        <= `FSC_RST_MAIN_CH;
      cfg_r.aux_source_channel         <= `FSC_RST_AUX_CH;
      cfg_r.aux_range_reference_select <= `FSC_RST_RANGE_REF;
      cfg_r.aux_range_percent          <= `FSC_RST_RANGE_PCT;
      cfg_r.source_combination_select  <= `FSC_RST_COMB;
      cfg_r.combined_offset_frequency  <= `FSC_RST_OFFSET;
      cfg_r.command_channel_binding    <= `FSC_RST_BIND;
      cfg_r.max_output_frequency       <= `FSC_RST_MAX_FREQ;
    end else if (cfg_we) begin
      cfg_r <= cfg_in;
    end
  end

  // Terminal pins cross two flops before any logic looks at them.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      motor_sync_r  <= 2'h0;
      switch_sync_r <= 2'h0;
    end else begin
      motor_sync_r  <= {motor_sync_r[0], motor_term_pin};
      switch_sync_r <= {switch_sync_r[0], switch_term_pin};
    end
  end

  // Decoded selector fields.
  wire [15:0] maxf      = cfg_r.max_output_frequency;
  wire [3:0]  mode      = digit({4'h0, cfg_r.source_combination_select}, 2'd0);
  wire [3:0]  op        = digit({4'h0, cfg_r.source_combination_select}, 2'd1);
  wire [3:0]  bind_pan  = digit(cfg_r.command_channel_binding, 2'd0);
  wire [3:0]  bind_trm  = digit(cfg_r.command_channel_binding, 2'd1);
  wire [3:0]  bind_com  = digit(cfg_r.command_channel_binding, 2'd2);
  wire        sw_closed = switch_term_assigned & switch_sync_r[1];
  wire [3:0]  aux_ch    = cfg_r.aux_source_channel;

  // Motor set: an assigned terminal wins over the stored selector.
  assign motor_nxt = motor_term_assigned ? motor_sync_r[1]
                                         : cfg_r.motor_set_select;

  // Main and independent auxiliary use one decoder, so codes mean the same.
  wire [16:0] main_x  = chan_value(cfg_r.main_source_channel, src, maxf);
  wire [16:0] aux_ind = chan_value(aux_ch, src, maxf);

  // Range reference follows the live main value when selected.
  wire [16:0] aux_ref = cfg_r.aux_range_reference_select ? main_x
                                                         : {1'b0, maxf};

  // Superposed auxiliary: digital is the up/down amount, analog is ranged.
  wire        aux_dig = (aux_ch == FSC_CH_NONE) || (aux_ch == FSC_CH_DIG);
  wire        aux_ana = is_scaled(aux_ch) && (aux_ch != FSC_CH_MSEG);
  wire [16:0] aux_rng = scale_pm(chan_pm(aux_ch, src), aux_ref,
                                 cfg_r.aux_range_percent);
  wire [16:0] aux_sup = aux_dig ? {1'b0, src.updown_adjust}
                      : aux_ana ? aux_rng : aux_ind;

  // Combining operations; the difference stops at zero rather than wrap.
  wire [17:0] op_sum  = {1'b0, main_x} + {1'b0, aux_sup};
  wire [17:0] op_diff = (main_x > aux_sup) ? {1'b0, main_x - aux_sup} : 18'h00000;
  wire [17:0] op_min  = {1'b0, (main_x < aux_sup) ? main_x : aux_sup};
  wire [17:0] op_max  = {1'b0, (main_x > aux_sup) ? main_x : aux_sup};
  wire [17:0] op_val  = (op == FSC_OP_DIFF) ? op_diff
                      : (op == FSC_OP_MIN)  ? op_min
                      : (op == FSC_OP_MAX)  ? op_max
                      : op_sum;
  // The offset can overflow 18 bits, since op_val from op_sum can reach 2^18 - 2.
  wire [17:0] comb_f  = op_val + {2'b00, cfg_r.combined_offset_frequency};

  // Mode switch; unused units codes fall back to the main source.
  wire [17:0] x18  = {1'b0, main_x};
  wire [17:0] y18  = {1'b0, aux_ind};
  wire [17:0] mode_f = (mode == FSC_MODE_COMB)  ? comb_f
                     : (mode == FSC_MODE_SW_XY) ? (sw_closed ? y18 : x18)
                     : (mode == FSC_MODE_SW_XC) ? (sw_closed ? comb_f : x18)
                     : (mode == FSC_MODE_SW_YC) ? (sw_closed ? comb_f : y18)
                     : x18;

  // Binding of the active command channel; digits may repeat freely.
  wire [3:0] bind_act = (cmd_source == FSC_CMD_TERM) ? bind_trm
                      : (cmd_source == FSC_CMD_COMM) ? bind_com
                      : bind_pan;
  wire        bound   = (bind_act != FSC_CH_NONE);
  wire [17:0] bound_f = {1'b0, chan_value(bind_act, src, maxf)};

  // A bound channel shuts out every other configured source.
  assign target_nxt = clamp_f(bound ? bound_f : mode_f, maxf);

  // Results are registered once per cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      target_r <= 16'h0000;
      motor_r  <= `FSC_RST_MOTOR;
      bound_r  <= 1'b0;
    end else begin
      target_r <= target_nxt;
      motor_r  <= motor_nxt;
      bound_r  <= bound;
    end
  end

  assign target_freq  = target_r;
  assign active_motor = motor_r;
  assign bound_in_use = bound_r;
  assign cfg_out      = cfg_r;

  // Checks on the selection logic.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Terminal held steady long enough to pass the synchroniser.
  sequence s_term_hi;
    (motor_term_assigned && motor_term_pin)[*3];
  endsequence
  sequence s_term_lo;
    (motor_term_assigned && !motor_term_pin)[*3];
  endsequence
  // No override over two edges, so the stored selector alone feeds the register.
  sequence s_no_term;
    !motor_term_assigned ##1 !motor_term_assigned;
  endsequence

  a_motor_term_hi: assert property (s_term_hi |=> active_motor)
    else $error("motor terminal high not obeyed");
  a_motor_term_lo: assert property (s_term_lo |=> !active_motor)
    else $error("motor terminal low not obeyed");
  a_motor_sel_cfg: assert property (s_no_term
      |-> active_motor == $past(cfg_r.motor_set_select))
    else $error("motor selector not followed");
  a_target_clamp: assert property (##1 target_freq <= $past(maxf))
    else $error("target above maximum frequency");

  // Each mode, with the switch terminal in the position that the mode names.
  a_main_only: assert property (!bound && mode == FSC_MODE_MAIN
      |=> target_freq == clamp_f($past(x18), $past(maxf)))
    else $error("main-only mode not honoured");
  a_comb_result: assert property (!bound && mode == FSC_MODE_COMB
      |=> target_freq == clamp_f($past(comb_f), $past(maxf)))
    else $error("combined mode not honoured");
  a_switch_xy: assert property (!bound && mode == FSC_MODE_SW_XY && !sw_closed
      |=> target_freq == clamp_f($past(x18), $past(maxf)))
    else $error("open switch must give main");
  a_switch_closed: assert property (!bound && mode == FSC_MODE_SW_XY && sw_closed
      |=> target_freq == clamp_f($past(y18), $past(maxf)))
    else $error("closed switch must give auxiliary");
  a_mid_closed: assert property (!bound && mode == FSC_MODE_SW_XC && sw_closed
      |=> target_freq == clamp_f($past(comb_f), $past(maxf)))
    else $error("closed switch must give combined result");
  a_aux_open: assert property (!bound && mode == FSC_MODE_SW_YC && !sw_closed
      |=> target_freq == clamp_f($past(y18), $past(maxf)))
    else $error("open switch must give auxiliary");
  a_bind_wins: assert property (bound
      |=> bound_in_use && target_freq == clamp_f($past(bound_f), $past(maxf)))
    else $error("bound channel not used");
  a_unbound_flag: assert property (!bound |=> !bound_in_use)
    else $error("binding flag raised without a binding");

  // Binding digits, worked out by plain division rather than the shared decoder.
  a_bind_panel: assert property (cmd_source == FSC_CMD_PANEL
      |-> bind_act == 4'(cfg_r.command_channel_binding % `FSC_DIGIT_BASE))
    else $error("panel binding digit misread");
  a_bind_term: assert property (cmd_source == FSC_CMD_TERM
      |-> bind_act == 4'((cfg_r.command_channel_binding / `FSC_DIGIT_BASE) % `FSC_DIGIT_BASE))
    else $error("terminal binding digit misread");
  a_bind_comm: assert property (cmd_source == FSC_CMD_COMM
      |-> bind_act == 4'((cfg_r.command_channel_binding / 10'h064) % `FSC_DIGIT_BASE))
    else $error("communication binding digit misread");

  // Auxiliary arithmetic against values that follow directly from the rules.
  a_diff_floor: assert property (op == FSC_OP_DIFF && main_x <= aux_sup
      |-> comb_f == {2'b00, cfg_r.combined_offset_frequency})
    else $error("difference not floored at zero");
  a_digital_aux: assert property (aux_dig && op == FSC_OP_SUM
      |-> comb_f == x18 + src.updown_adjust
          + cfg_r.combined_offset_frequency)
    else $error("digital auxiliary not added to main");
  a_range_zero: assert property (aux_ana && cfg_r.aux_range_percent == 8'h00
      |-> aux_sup == 17'h00000)
    else $error("zero range must give zero auxiliary");
  a_range_of_max: assert property (aux_ana && !cfg_r.aux_range_reference_select
      && chan_pm(aux_ch, src) == 11'h3e8 && cfg_r.aux_range_percent == 8'h32
      |-> aux_sup == {1'b0, maxf >> 1})
    else $error("full-scale auxiliary at half range must give half the maximum");
  a_range_of_main: assert property (aux_ana && cfg_r.aux_range_reference_select
      && chan_pm(aux_ch, src) == 11'h3e8 && cfg_r.aux_range_percent == 8'h32
      |-> aux_sup == (main_x >> 1))
    else $error("full-scale auxiliary at half range must give half the main value");
  a_full_scale: assert property (is_scaled(aux_ch)
      && chan_pm(aux_ch, src) == 11'h3e8
      |-> aux_ind == {1'b0, maxf})
    else $error("full-scale reading must equal the maximum frequency");

endmodule : fsc_combiner
`default_nettype wire

// [fsc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Far side: channel sources and the two digital input terminals.
module fsc_far_model
  import fsc_pkg::*;
(
  // Clock.
  input  wire logic        clock,
  // Values the bench asks for.
  input  wire logic [15:0] dig_val,
  input  wire logic [15:0] adj_val,
  input  wire logic [10:0] ai_val,
  input  wire logic [15:0] plc_val,
  input  wire logic        motor_closed,
  input  wire logic        switch_closed,
  // Toward the block.
  output var fsc_src_s     src,
  output var logic         motor_term_pin,
  output var logic         switch_term_pin
);
  logic [15:0] churn = 16'h0000;

  // Unselected channels keep moving so a wrong selection never looks right by luck.
  always @(negedge clock) begin
    churn <= churn + 16'h0101;
  end

  // Sources that scenarios select follow the bench; the rest churn.
  always_comb begin
    src.digital_freq          = dig_val;
    src.updown_adjust         = adj_val;
    src.analog_input_one      = ai_val;
    src.analog_input_two      = churn[10:0];
    src.analog_input_three    = ~churn[10:0];
    src.pulse_frequency_input = churn[12:2];
    src.multi_segment         = churn[11:1];
    src.plc_freq              = plc_val;
    src.pid_freq              = churn;
    src.comm_freq             = ~churn;
    motor_term_pin            = motor_closed;
    switch_term_pin           = switch_closed;
  end
endmodule : fsc_far_model

`default_nettype wire

// [frequency_source_combiner_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module frequency_source_combiner_bench;
  import fsc_pkg::*;
  logic        clock, sys_rst, cfg_we, m_asg, s_asg, m_cl, s_cl;
  logic        motor_term_pin, switch_term_pin, active_motor, bound_in_use;
  logic [15:0] dig, adj, plc, target_freq;
  logic [10:0] ai;
  fsc_cfg_s    cfg_in, cfg_out;
  fsc_src_s    src;
  fsc_cmd_e    cmd_source;
  int          n_fail, n_compared;

  fsc_combiner i_dut (.clock(clock), .sys_rst(sys_rst), .cfg_we(cfg_we), .cfg_in(cfg_in),
    .cfg_out(cfg_out), .src(src), .motor_term_pin(motor_term_pin),
    .motor_term_assigned(m_asg), .switch_term_pin(switch_term_pin),
    .switch_term_assigned(s_asg), .cmd_source(cmd_source), .target_freq(target_freq),
    .active_motor(active_motor), .bound_in_use(bound_in_use));

  fsc_far_model i_far (.clock(clock), .dig_val(dig), .adj_val(adj), .ai_val(ai),
    .plc_val(plc), .motor_closed(m_cl), .switch_closed(s_cl), .src(src),
    .motor_term_pin(motor_term_pin), .switch_term_pin(switch_term_pin));

  // Clock at 200 MHz.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // Main and auxiliary codes are always kept distinct in what is loaded.
  function automatic fsc_cfg_s mk(input logic m, input logic [3:0] mc, input logic [3:0] ac,
    input logic r, input logic [7:0] p, input logic [5:0] c, input logic [15:0] o,
    input logic [9:0] b);
    mk = '{m, mc, ac, r, p, c, o, b, 16'h1388};
  endfunction : mk

  // Waits long enough for the settings and the synced terminals to reach the output.
  task automatic settle();
    repeat (5) @(negedge clock);
  endtask : settle

  task automatic load(input fsc_cfg_s v);
    cfg_in = v;
    cfg_we = 1'b1;
    @(negedge clock);
    cfg_we = 1'b0;
    settle();
  endtask : load

  task automatic t_reset();
    check(target_freq, 16'h0000, "reset target");
    check(cfg_out.max_output_frequency, 16'h1388, "reset max");
    check(16'(cfg_out.aux_range_percent), 16'h0000, "reset pct");
    check(cfg_out.combined_offset_frequency, 16'h0000, "reset offset");
    check(16'(cfg_out.command_channel_binding), 16'h0000, "reset binding");
    check(16'(cfg_out.source_combination_select), 16'h0000, "reset combination");
    check(16'(active_motor), 16'h0000, "reset motor");
  endtask : t_reset

  // Reset held three cycles; in mid-run it must bring the maximum, range percent, offset, binding and combination settings back to default.
  task automatic t_rerun();
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    t_reset();
    sys_rst = 1'b0;
    @(negedge clock);
  endtask : t_rerun

  // Main 1000, auxiliary PLC 600, offset 100 through the four operations.
  task automatic t_ops();
    logic [15:0] exp [4];
    exp = '{16'h06a4, 16'h01f4, 16'h02bc, 16'h044c};
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h00, 16'h0064, 10'h000));
    check(target_freq, 16'h03e8, "main only");
    for (int op = 0; op < 4; op++) begin
      load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'(10 * op + 1), 16'h0064, 10'h000));
      check(target_freq, exp[op], "operation");
    end
    plc = 16'h1194;
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h01, 16'h0064, 10'h000));
    check(target_freq, 16'h1388, "clamp");
    plc = 16'h0258;
  endtask : t_ops

  // Modes 2 to 4 with the switch terminal closed then open.
  task automatic t_switch();
    logic [15:0] cl [3];
    logic [15:0] op [3];
    cl = '{16'h0258, 16'h06a4, 16'h06a4};
    op = '{16'h03e8, 16'h03e8, 16'h0258};
    s_asg = 1'b1;
    for (int m = 0; m < 3; m++) begin
      s_cl = 1'b1;
      load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'(m + 2), 16'h0064, 10'h000));
      check(target_freq, cl[m], "switch closed");
      s_cl = 1'b0;
      settle();
      check(target_freq, op[m], "switch open");
    end
    s_cl = 1'b1;
    s_asg = 1'b0;
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h02, 16'h0064, 10'h000));
    check(target_freq, 16'h03e8, "unassigned switch");
    s_asg = 1'b1;
  endtask : t_switch

  // Superposed auxiliary: scaling, reference, live tracking, digital adjust.
  task automatic t_aux();
    ai = 11'h3e8;
    load(mk(1'b0, 4'h1, 4'h2, 1'b0, 8'h32, 6'h01, 16'h0000, 10'h000));
    check(target_freq, 16'h0dac, "aux of max");
    load(mk(1'b0, 4'h1, 4'h2, 1'b1, 8'h32, 6'h01, 16'h0000, 10'h000));
    check(target_freq, 16'h05dc, "aux of main");
    dig = 16'h07d0;
    settle();
    check(target_freq, 16'h0bb8, "aux tracks main");
    ai = 11'h1f4;
    load(mk(1'b0, 4'h1, 4'h2, 1'b1, 8'h96, 6'h01, 16'h0000, 10'h000));
    check(target_freq, 16'h0dac, "aux at 150");
    dig = 16'h03e8;
    // Main on PLC so that main and auxiliary never share a channel code.
    load(mk(1'b0, 4'h7, 4'h1, 1'b0, 8'h00, 6'h01, 16'h0000, 10'h000));
    check(target_freq, 16'h0320, "digital adjust");
    // Half scale keeps the expected value clear of the clamp at maximum.
    load(mk(1'b0, 4'h1, 4'h2, 1'b0, 8'h00, 6'h02, 16'h0000, 10'h000));
    check(target_freq, 16'h09c4, "independent aux");
  endtask : t_aux

  // Panel bound to PLC, terminal to analog one, communication unbound.
  task automatic t_bind();
    ai = 11'h1f4;
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h01, 16'h0064, 10'h01b));
    check(target_freq, 16'h0258, "panel bound");
    check(16'(bound_in_use), 16'h0001, "panel in use");
    cmd_source = FSC_CMD_TERM;
    settle();
    check(target_freq, 16'h09c4, "terminal bound");
    cmd_source = FSC_CMD_COMM;
    settle();
    check(target_freq, 16'h06a4, "comm unbound");
    check(16'(bound_in_use), 16'h0000, "comm not in use");
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h01, 16'h0064, 10'h309));
    check(target_freq, 16'h0258, "shared binding");
    cmd_source = FSC_CMD_PANEL;
    ai = 11'h3e8;
  endtask : t_bind

  // Selector alone, then the terminal overriding it both ways.
  task automatic t_motor();
    load(mk(1'b1, 4'h1, 4'h7, 1'b0, 8'h00, 6'h00, 16'h0000, 10'h000));
    check(16'(active_motor), 16'h0001, "selector two");
    m_asg = 1'b1;
    settle();
    check(16'(active_motor), 16'h0000, "terminal open wins");
    m_cl = 1'b1;
    load(mk(1'b0, 4'h1, 4'h7, 1'b0, 8'h00, 6'h00, 16'h0000, 10'h000));
    check(16'(active_motor), 16'h0001, "terminal closed wins");
    m_asg = 1'b0;
    settle();
    check(16'(active_motor), 16'h0000, "selector one");
  endtask : t_motor

  // Watchdog: the full sequence needs well under 1000 cycles.
  initial begin
    repeat (4000) @(posedge clock);
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    n_fail = 0;
    n_compared = 0;
    cfg_we = 1'b0;
    cfg_in = '0;
    m_asg = 1'b0;
    s_asg = 1'b0;
    m_cl = 1'b0;
    s_cl = 1'b0;
    dig = 16'h03e8;
    adj = 16'h00c8;
    plc = 16'h0258;
    ai = 11'h3e8;
    cmd_source = FSC_CMD_PANEL;
    t_rerun();
    t_ops();
    t_switch();
    t_aux();
    t_bind();
    t_rerun();
    t_motor();
    summarize();
  end
endmodule : frequency_source_combiner_bench

`default_nettype wire
